/* pcsk_asserts.sv */
// Purpose: Port-level checks on program counter, stack flags and indirect timing
// Assumes: Single core clock; bound to the top module
// Notes:   Calls that overflow may legally leave the counter cleared
`timescale 1ns/1ps
`default_nettype none
module pcsk_asserts (
    input wire logic               i_clk_sys, i_arst_n, i_ce, i_op_valid,
    input wire pcsk_pkg::pcsk_op_t i_op,
    input wire logic [10:0]        i_op_arg,
    input wire logic [7:0]         i_wreg,
    input wire logic [14:0]        o_pc,
    input wire logic               o_stack_reset, o_stack_ovf, o_stack_unf,
    input wire logic               o_pready, o_dm_re, o_pm_re
);
    import pcsk_pkg::*;
    wire logic        go      = i_ce && i_op_valid;
    wire logic [14:0] rel_off = {{6{i_op_arg[8]}}, i_op_arg[8:0]};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    call_target_a: assert property (
        go && i_op == OP_CALL |=> o_stack_ovf || o_pc[10:0] == $past(i_op_arg))
        else $error("call target wrong");
    wcall_target_a: assert property (
        go && i_op == OP_CALL_W |=> o_stack_ovf || o_pc[7:0] == $past(i_wreg))
        else $error("computed call target wrong");
    wbranch_target_a: assert property (
        go && i_op == OP_BR_W |=> o_pc == $past(o_pc) + 15'h0001 + {7'h00, $past(i_wreg)})
        else $error("working branch target wrong");
    rel_branch_a: assert property (
        go && i_op == OP_BR_REL |=> o_pc == $past(o_pc) + 15'h0001 + $past(rel_off))
        else $error("relative branch target wrong");
    fault_clear_a: assert property (
        o_stack_reset |-> o_pc == 15'h0000 && (o_stack_ovf || o_stack_unf))
        else $error("fault reset left counter or flag");
    unf_cause_a: assert property (
        !o_stack_unf && !(go && i_op inside {OP_RET, OP_RET_LIT, OP_RET_INT}) |=> !o_stack_unf)
        else $error("underflow flag without pop");
    ovf_cause_a: assert property (
        !o_stack_ovf && !(go && i_op inside {OP_CALL, OP_CALL_W, OP_INT}) |=> !o_stack_ovf)
        else $error("overflow flag without push");
    prog_extra_a: assert property (
        o_pm_re |-> !o_pready ##1 !o_pready ##1 o_pready)
        else $error("program read timing wrong");
    data_read_a: assert property (
        o_dm_re |-> !o_pm_re ##2 o_pready)
        else $error("data read timing wrong");
endmodule
bind pcsk_top pcsk_asserts u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_op_arg(i_op_arg), .i_wreg(i_wreg), .o_pc(o_pc),
    .o_stack_reset(o_stack_reset), .o_stack_ovf(o_stack_ovf), .o_stack_unf(o_stack_unf),
    .o_pready(o_pready), .o_dm_re(o_dm_re), .o_pm_re(o_pm_re));
`default_nettype wire

/* pcsk_fsr_map.sv */
// Purpose: Decode a 16-bit indirect pointer into a memory region and address
// Assumes: Purely combinational
// Notes:   Linear region folds onto the 80-byte general purpose block of each bank
`timescale 1ns/1ps
`default_nettype none
module pcsk_fsr_map (
    // Pointer in
    input  wire logic [15:0]         i_addr,
    // Decoded target
    output pcsk_pkg::pcsk_rgn_t      o_region,
    output logic [11:0]              o_dm_addr,
    output logic [14:0]              o_pm_addr
);
    import pcsk_pkg::*;

    logic [11:0] off;
    logic [11:0] bank;
    logic [11:0] rem;

    assign off  = 12'(i_addr - LIN_BASE);
    assign bank = off / LIN_BANK_SZ;
    assign rem  = off % LIN_BANK_SZ;

    always_comb begin
        o_region  = RG_NONE;
        o_dm_addr = '0;
        o_pm_addr = i_addr[14:0];
        if (i_addr[15]) begin
            o_region = RG_PROG;
        end else if (i_addr <= TRAD_END) begin
            o_dm_addr = i_addr[11:0];
            o_region  = (i_addr[6:0] < IND_PORTS) ? RG_SELF : RG_TRAD;
        end else if (i_addr >= LIN_BASE && i_addr <= LIN_END) begin
            o_region  = RG_LIN;
            o_dm_addr = {bank[4:0], 7'(LIN_RAM_BASE + rem[6:0])};
        end
    end
endmodule
`default_nettype wire

/* pcsk_mem_model.sv */
// Purpose: Data and program memory behind the indirect path
// Assumes: Answers one cycle after each strobe
// Notes:   Read data toggles when not strobed so stale values never match;
//          memory starts non-zero except where the low address byte is FF, so a read that should give zero shows up
`timescale 1ns/1ps
`default_nettype none
module pcsk_mem_model (
    input  wire logic        i_clk_sys, i_dm_re, i_dm_we, i_pm_re,
    input  wire logic [11:0] i_dm_addr,
    input  wire logic [7:0]  i_dm_wdata,
    input  wire logic [14:0] i_pm_addr,
    output logic [7:0]       o_dm_rdata,
    output logic [13:0]      o_pm_rdata
);
    logic [7:0] mem [0:4095];
    initial begin
        for (int k = 0; k < 4096; k++) mem[k] = ~k[7:0];
        o_dm_rdata = 8'h00;
        o_pm_rdata = 14'h0000;
    end
    always @(posedge i_clk_sys) begin
        if (i_dm_we) mem[i_dm_addr] <= i_dm_wdata;
        o_dm_rdata <= i_dm_re ? mem[i_dm_addr] : ~o_dm_rdata;
        o_pm_rdata <= i_pm_re ? {i_pm_addr[5:0], i_pm_addr[7:0] ^ 8'hA5} : ~o_pm_rdata;
    end
endmodule
`default_nettype wire

/* pcsk_pkg.sv */
// Purpose: Shared constants and types for the program flow and addressing block
// Assumes: One core clock; APB register access with 32-bit data
// Notes:   Byte offsets are word aligned; narrow registers sit in the low bits

package pcsk_pkg;

    localparam int unsigned PC_W      = 15;
    localparam int unsigned STK_DEPTH = 16;

    // Register byte offsets
    localparam logic [7:0] OFF_PC_LO    = 8'h00;
    localparam logic [7:0] OFF_PC_LATCH = 8'h04;
    localparam logic [7:0] OFF_SP       = 8'h08;
    localparam logic [7:0] OFF_TOS_LO   = 8'h0C;
    localparam logic [7:0] OFF_TOS_HI   = 8'h10;
    localparam logic [7:0] OFF_PTR0_LO  = 8'h14;
    localparam logic [7:0] OFF_PTR0_HI  = 8'h18;
    localparam logic [7:0] OFF_PTR1_LO  = 8'h1C;
    localparam logic [7:0] OFF_PTR1_HI  = 8'h20;
    localparam logic [7:0] OFF_PORT0    = 8'h24;
    localparam logic [7:0] OFF_PORT1    = 8'h28;
    localparam logic [7:0] OFF_PWR_STAT = 8'h2C;

    // Field positions and reset values
    localparam int unsigned STAT_UNF_BIT = 0;
    localparam int unsigned STAT_OVF_BIT = 1;
    localparam int unsigned FLT_EN_BIT   = 9;
    localparam logic [14:0] PC_RST       = 15'h0000;
    localparam logic [14:0] VEC_INT      = 15'h0004;
    localparam logic [4:0]  SP_EMPTY     = 5'h1F;
    localparam logic [4:0]  SP_FULL      = 5'h0F;

    // Indirect address map
    localparam logic [15:0] TRAD_END     = 16'h0FFF;
    localparam logic [15:0] LIN_BASE     = 16'h2000;
    localparam logic [15:0] LIN_END      = 16'h29AF;
    localparam logic [11:0] LIN_BANK_SZ  = 12'h050;
    localparam logic [6:0]  LIN_RAM_BASE = 7'h20;
    localparam logic [6:0]  IND_PORTS    = 7'h02;

    typedef enum logic [3:0] {
        OP_STEP, OP_PC_LO_WR, OP_CALL, OP_CALL_W, OP_BR_W, OP_BR_REL,
        OP_RET, OP_RET_LIT, OP_RET_INT, OP_INT
    } pcsk_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXTRA = 2'b01,
        ST_CAP   = 2'b11,
        ST_DONE  = 2'b10
    } pcsk_st_t;

    typedef enum logic [2:0] {
        RG_NONE, RG_TRAD, RG_LIN, RG_PROG, RG_SELF
    } pcsk_rgn_t;

endpackage

/* pcsk_stack.sv */
// Purpose: Sixteen-entry return stack with five-bit pointer
// Assumes: Push and pop never requested together
// Notes:   Fault with reset enabled returns the pointer to empty
`timescale 1ns/1ps
`default_nettype none
module pcsk_stack (
    // Clock, reset, enable
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    // Stack port
    pcsk_stk_if.stk   stk
);
    import pcsk_pkg::*;

    logic [PC_W-1:0] mem_q [STK_DEPTH];
    logic [4:0]      ptr_q;
    logic [4:0]      ptr_d;
    logic            fault;

    assign stk.ovf = stk.push && (ptr_q == SP_FULL);
    assign stk.unf = stk.pop && (ptr_q == SP_EMPTY);
    assign fault   = stk.flt_en && (stk.ovf || stk.unf);
    assign stk.ptr = ptr_q;
    assign stk.tos = mem_q[ptr_q[3:0]];

    always_comb begin
        ptr_d = ptr_q;
        if (fault) begin
            ptr_d = SP_EMPTY;
        end else if (stk.push) begin
            ptr_d = {1'b0, 4'(ptr_q[3:0] + 4'h1)};
        end else if (stk.pop) begin
            ptr_d = 5'(ptr_q - 5'h01);
        end else if (stk.ptr_wr) begin
            ptr_d = stk.wdata[4:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ptr_q <= SP_EMPTY;
        end else if (i_ce) begin
            ptr_q <= ptr_d;
        end
    end

    for (genvar e = 0; e < STK_DEPTH; e++) begin : g_ent
        always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
            if (!i_arst_n) begin
                mem_q[e] <= '0;
            end else if (i_ce) begin
                if (stk.push && !fault && ptr_d[3:0] == 4'(e)) begin
                    mem_q[e] <= stk.push_pc;
                end else if (stk.tos_lo_wr && ptr_q[3:0] == 4'(e)) begin
                    mem_q[e][7:0] <= stk.wdata;
                end else if (stk.tos_hi_wr && ptr_q[3:0] == 4'(e)) begin
                    mem_q[e][14:8] <= stk.wdata[6:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* pcsk_stk_if.sv */
// Purpose: Control and status bundle between the core logic and the return stack
// Assumes: Single clock domain
// Notes:   Fault flags are combinational on push and pop
`timescale 1ns/1ps
`default_nettype none
interface pcsk_stk_if;
    logic        push;
    logic        pop;
    logic        ptr_wr;
    logic        tos_lo_wr;
    logic        tos_hi_wr;
    logic        flt_en;
    logic [7:0]  wdata;
    logic [14:0] push_pc;
    logic [4:0]  ptr;
    logic [14:0] tos;
    logic        ovf;
    logic        unf;
    modport ctl (output push, pop, ptr_wr, tos_lo_wr, tos_hi_wr, flt_en, wdata, push_pc,
                 input ptr, tos, ovf, unf);
    modport stk (input push, pop, ptr_wr, tos_lo_wr, tos_hi_wr, flt_en, wdata, push_pc,
                 output ptr, tos, ovf, unf);
endinterface
`default_nettype wire

/* pcsk_top.sv */
// Purpose: Program counter, return stack and indirect addressing of an 8-bit core
// Assumes: Core ops come from same-clock decoder logic; memories answer one cycle after strobe
// Notes:   Registers reached over APB; indirect ports stall the bus while memory is read
`timescale 1ns/1ps
`default_nettype none
module pcsk_top (
    // Clock, reset, enable
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_ce,
    // APB slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic [31:0]               o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // Instruction decoder
    input  wire logic                 i_op_valid,
    input  wire pcsk_pkg::pcsk_op_t   i_op,
    input  wire logic [10:0]          i_op_arg,
    input  wire logic [7:0]           i_wreg,
    // Configuration
    input  wire logic [13:0]          i_cfg_word2,
    // Program flow status
    output logic [14:0]               o_pc,
    output logic                      o_stack_reset,
    output logic                      o_stack_ovf,
    output logic                      o_stack_unf,
    // Data memory
    output logic [11:0]               o_dm_addr,
    output logic                      o_dm_re,
    output logic                      o_dm_we,
    output logic [7:0]                o_dm_wdata,
    input  wire logic [7:0]           i_dm_rdata,
    // Program memory
    output logic [14:0]               o_pm_addr,
    output logic                      o_pm_re,
    input  wire logic [13:0]          i_pm_rdata
);
    import pcsk_pkg::*;

    pcsk_stk_if stk ();

    logic [14:0] pc_q;
    logic [6:0]  latch_q;
    logic [15:0] iptr_q [2];
    logic        ovf_q;
    logic        unf_q;
    logic        rst_pls_q;
    pcsk_st_t    st_q;
    logic [7:0]  prdata_q;

    logic        access;
    logic        done;
    logic        hit;
    logic        is_indf;
    logic        sel;
    logic        wr_ev;
    logic        push;
    logic        pop;
    logic        fault;
    logic        dm_ok;
    logic        is_prog;
    logic [7:0]  rd_reg;
    logic [15:0] ind_addr;
    pcsk_rgn_t   region;

    // Bus decode
    assign access  = i_psel && i_penable;
    assign done    = (st_q == ST_DONE);
    assign is_indf = (i_paddr == OFF_PORT0) || (i_paddr == OFF_PORT1);
    assign sel     = (i_paddr == OFF_PORT1);
    assign wr_ev   = i_ce && access && i_pwrite && done && hit;

    assign ind_addr = iptr_q[sel];
    assign dm_ok    = (region == RG_TRAD) || (region == RG_LIN);
    assign is_prog  = (region == RG_PROG);

    pcsk_fsr_map u_map (
        .i_addr    (ind_addr),
        .o_region  (region),
        .o_dm_addr (o_dm_addr),
        .o_pm_addr (o_pm_addr)
    );

    always_comb begin
        hit    = 1'b1;
        rd_reg = 8'h00;
        case (i_paddr)
            OFF_PC_LO: begin
                rd_reg = pc_q[7:0];
            end
            OFF_PC_LATCH: begin
                rd_reg = {1'b0, latch_q};
            end
            OFF_SP: begin
                rd_reg = {3'b000, stk.ptr};
            end
            OFF_TOS_LO: begin
                rd_reg = stk.tos[7:0];
            end
            OFF_TOS_HI: begin
                rd_reg = {1'b0, stk.tos[14:8]};
            end
            OFF_PTR0_LO: begin
                rd_reg = iptr_q[0][7:0];
            end
            OFF_PTR0_HI: begin
                rd_reg = iptr_q[0][15:8];
            end
            OFF_PTR1_LO: begin
                rd_reg = iptr_q[1][7:0];
            end
            OFF_PTR1_HI: begin
                rd_reg = iptr_q[1][15:8];
            end
            OFF_PORT0, OFF_PORT1: begin
                rd_reg = 8'h00;
            end
            OFF_PWR_STAT: begin
                rd_reg = 8'h00;
                rd_reg[STAT_OVF_BIT] = ovf_q;
                rd_reg[STAT_UNF_BIT] = unf_q;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Bus sequencer: plain registers answer in the second access cycle
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_IDLE;
        end else if (i_ce) begin
            case (st_q)
                ST_IDLE: begin
                    if (access && is_indf && is_prog) begin
                        st_q <= ST_EXTRA;
                    end else if (access && is_indf) begin
                        st_q <= ST_CAP;
                    end else if (access) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_EXTRA: begin
                    st_q <= ST_CAP;
                end
                ST_CAP: begin
                    st_q <= ST_DONE;
                end
                ST_DONE: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prdata_q <= 8'h00;
        end else if (i_ce) begin
            if (st_q == ST_IDLE && access && !is_indf) begin
                prdata_q <= rd_reg;
            end else if (st_q == ST_CAP) begin
                if (i_pwrite) begin
                    prdata_q <= 8'h00;
                end else if (is_prog) begin
                    prdata_q <= i_pm_rdata[7:0];
                end else if (dm_ok) begin
                    prdata_q <= i_dm_rdata;
                end else begin
                    prdata_q <= 8'h00;
                end
            end
        end
    end

    assign o_prdata  = {24'h000000, prdata_q};
    assign o_pready  = i_ce && done;
    assign o_pslverr = i_ce && done && !hit;

    // Memory strobes; self-pointing and unmapped targets never strobe
    assign o_dm_re    = i_ce && access && !i_pwrite && is_indf && dm_ok
                        && (st_q == ST_IDLE);
    assign o_pm_re    = i_ce && access && !i_pwrite && is_indf
                        && (st_q == ST_EXTRA);
    assign o_dm_we    = wr_ev && is_indf && dm_ok;
    assign o_dm_wdata = i_pwdata[7:0];

    // Stack requests
    assign push = i_ce && i_op_valid
                  && (i_op == OP_CALL || i_op == OP_CALL_W || i_op == OP_INT);
    assign pop  = i_ce && i_op_valid
                  && (i_op == OP_RET || i_op == OP_RET_LIT || i_op == OP_RET_INT);

    assign stk.push    = push;
    assign stk.pop     = pop;
    assign stk.push_pc = 15'(pc_q + 15'h0001);
    assign stk.ptr_wr    = wr_ev && (i_paddr == OFF_SP);
    assign stk.tos_lo_wr = wr_ev && (i_paddr == OFF_TOS_LO);
    assign stk.tos_hi_wr = wr_ev && (i_paddr == OFF_TOS_HI);
    assign stk.wdata     = i_pwdata[7:0];
    assign stk.flt_en    = i_cfg_word2[FLT_EN_BIT];
    assign fault       = stk.flt_en && (stk.ovf || stk.unf);

    pcsk_stack u_stack (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .stk       (stk)
    );

    // Program counter
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pc_q <= PC_RST;
        end else if (i_ce) begin
            if (fault) begin
                pc_q <= PC_RST;
            end else if (i_op_valid) begin
                case (i_op)
                    OP_STEP: begin
                        pc_q <= 15'(pc_q + 15'h0001);
                    end
                    OP_PC_LO_WR: begin
                        pc_q <= {latch_q, i_op_arg[7:0]};
                    end
                    OP_CALL: begin
                        pc_q <= {latch_q[6:3], i_op_arg};
                    end
                    OP_CALL_W: begin
                        pc_q <= {latch_q, i_wreg};
                    end
                    OP_BR_W: begin
                        pc_q <= 15'(pc_q + 15'h0001 + {7'h00, i_wreg});
                    end
                    OP_BR_REL: begin
                        pc_q <= 15'(pc_q + 15'h0001
                                    + {{6{i_op_arg[8]}}, i_op_arg[8:0]});
                    end
                    OP_RET, OP_RET_LIT, OP_RET_INT: begin
                        pc_q <= stk.tos;
                    end
                    OP_INT: begin
                        pc_q <= VEC_INT;
                    end
                    default: begin
                        pc_q <= pc_q;
                    end
                endcase
            end else if (wr_ev && i_paddr == OFF_PC_LO) begin
                pc_q <= {latch_q, i_pwdata[7:0]};
            end
        end
    end

    // High latch: only APB writes and a stack fault reset change it
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_q <= 7'h00;
        end else if (i_ce) begin
            if (fault) begin
                latch_q <= 7'h00;
            end else if (wr_ev && i_paddr == OFF_PC_LATCH) begin
                latch_q <= i_pwdata[6:0];
            end
        end
    end

    // Indirect pointers, one per port
    for (genvar n = 0; n < 2; n++) begin : g_iptr
        localparam logic [7:0] OFF_LO = (n == 0) ? OFF_PTR0_LO : OFF_PTR1_LO;
        localparam logic [7:0] OFF_HI = (n == 0) ? OFF_PTR0_HI : OFF_PTR1_HI;
        always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
            if (!i_arst_n) begin
                iptr_q[n] <= 16'h0000;
            end else if (i_ce) begin
                if (wr_ev && i_paddr == OFF_LO) begin
                    iptr_q[n][7:0] <= i_pwdata[7:0];
                end else if (wr_ev && i_paddr == OFF_HI) begin
                    iptr_q[n][15:8] <= i_pwdata[7:0];
                end
            end
        end
    end

    // Sticky fault flags; a new fault wins over a software clear
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ovf_q <= 1'b0;
        end else if (i_ce) begin
            if (stk.ovf) begin
                ovf_q <= 1'b1;
            end else if (wr_ev && i_paddr == OFF_PWR_STAT && !i_pwdata[STAT_OVF_BIT]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            unf_q <= 1'b0;
        end else if (i_ce) begin
            if (stk.unf) begin
                unf_q <= 1'b1;
            end else if (wr_ev && i_paddr == OFF_PWR_STAT && !i_pwdata[STAT_UNF_BIT]) begin
                unf_q <= 1'b0;
            end
        end
    end

    // Fault reset pulse to the rest of the device
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_pls_q <= 1'b0;
        end else if (i_ce) begin
            rst_pls_q <= fault;
        end
    end

    assign o_pc          = pc_q;
    assign o_stack_reset = rst_pls_q;
    assign o_stack_ovf   = ovf_q;
    assign o_stack_unf   = unf_q;
endmodule
`default_nettype wire

/* pcsk_top_tb_top.sv */
// Purpose: Register and op level tests of program flow, stack and indirect access
// Assumes: Clock enable high except for one frozen op
// Notes:   Stack faults run with the fault reset off, then on
`timescale 1ns/1ps
`default_nettype none
module pcsk_top_tb_top;
    import pcsk_pkg::*;
    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_op_valid = 1'b0, i_ce = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr, e;
    logic [7:0] i_paddr = 8'h00, i_wreg = 8'h00, r, dm_wdata, dm_rdata;
    logic [31:0] i_pwdata = 32'h00000000, o_prdata;
    logic [10:0] i_op_arg = 11'h000;
    logic [13:0] i_cfg_word2 = 14'h0000, pm_rdata;
    logic [14:0] o_pc, pm_addr;
    logic [11:0] dm_addr;
    logic o_stack_reset, o_stack_ovf, o_stack_unf, dm_re, dm_we, pm_re;
    pcsk_op_t i_op = OP_STEP;
    int n_mismatch = 0, compares = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    pcsk_top u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_op(i_op),
        .i_op_valid(i_op_valid), .i_op_arg(i_op_arg), .i_wreg(i_wreg), .o_pc(o_pc),
        .i_cfg_word2(i_cfg_word2), .o_stack_reset(o_stack_reset), .o_stack_ovf(o_stack_ovf),
        .o_stack_unf(o_stack_unf), .o_dm_addr(dm_addr), .o_dm_re(dm_re), .o_dm_we(dm_we),
        .o_dm_wdata(dm_wdata), .i_dm_rdata(dm_rdata), .o_pm_addr(pm_addr), .o_pm_re(pm_re),
        .i_pm_rdata(pm_rdata));
    pcsk_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_dm_re(dm_re), .i_dm_we(dm_we),
        .i_pm_re(pm_re), .i_dm_addr(dm_addr), .i_dm_wdata(dm_wdata), .i_pm_addr(pm_addr),
        .o_dm_rdata(dm_rdata), .o_pm_rdata(pm_rdata));
    task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h000000, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        r = o_prdata[7:0];
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk("prdata", {7'h00, r}, {7'h00, x});
    endtask
    task automatic op(input pcsk_op_t c, input logic [10:0] a, input logic [7:0] w);
        @(posedge i_clk_sys);
        i_op_valid <= 1'b1;
        i_op <= c;
        i_op_arg <= a;
        i_wreg <= w;
        @(posedge i_clk_sys);
        i_op_valid <= 1'b0;
        #1;
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        chk("pc", o_pc, 15'h0000);
        rd(8'h08, 8'h1F);
        apb(1'b1, 8'h04, 8'h15);
        apb(1'b1, 8'h00, 8'h34);
        chk("pc", o_pc, 15'h1534);
        op(OP_CALL, 11'h123, 8'h00);
        chk("pc", o_pc, 15'h1123);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h35);
        rd(8'h10, 8'h15);
        rd(8'h04, 8'h15);
        op(OP_CALL_W, 11'h000, 8'h77);
        chk("pc", o_pc, 15'h1577);
        op(OP_RET, 11'h000, 8'h00);
        chk("pc", o_pc, 15'h1124);
        op(OP_RET_LIT, 11'h000, 8'h00);
        chk("pc", o_pc, 15'h1535);
        rd(8'h08, 8'h1F);
        op(OP_BR_W, 11'h000, 8'hF0);
        chk("pc", o_pc, 15'h1626);
        op(OP_BR_REL, 11'h1F0, 8'h00);
        chk("pc", o_pc, 15'h1617);
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        op(OP_STEP, 11'h000, 8'h00);
        chk("pc", o_pc, 15'h1617);
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h0C, 8'hAB);
        apb(1'b1, 8'h10, 8'h12);
        op(OP_RET_INT, 11'h000, 8'h00);
        chk("pc", o_pc, 15'h12AB);
        for (int k = 0; k < 17; k++) op(OP_INT, 11'h000, 8'h00);
        chk("ovf", o_stack_ovf, 1'b1);
        chk("pc", o_pc, 15'h0004);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h05);
        @(posedge i_clk_sys);
        i_cfg_word2 <= 14'h0200;
        apb(1'b1, 8'h2C, 8'h00);
        apb(1'b1, 8'h08, 8'h0F);
        op(OP_CALL, 11'h055, 8'h00);
        chk("pc", o_pc, 15'h0000);
        rd(8'h08, 8'h1F);
        apb(1'b1, 8'h00, 8'h40);
        op(OP_RET, 11'h000, 8'h00);
        chk("unf", o_stack_unf, 1'b1);
        chk("pc", o_pc, 15'h0000);
        apb(1'b1, 8'h18, 8'h00);
        apb(1'b1, 8'h14, 8'h40);
        apb(1'b1, 8'h24, 8'h5A);
        rd(8'h24, 8'h5A);
        apb(1'b1, 8'h20, 8'h20);
        apb(1'b1, 8'h1C, 8'h50);
        apb(1'b1, 8'h28, 8'h3C);
        apb(1'b1, 8'h14, 8'hA0);
        rd(8'h24, 8'h3C);
        apb(1'b1, 8'h14, 8'h01);
        rd(8'h24, 8'h00);
        apb(1'b1, 8'h18, 8'h10);
        rd(8'h24, 8'h00);
        apb(1'b1, 8'h18, 8'h80);
        apb(1'b1, 8'h14, 8'h12);
        rd(8'h24, 8'hB7);
        apb(1'b0, 8'h30, 8'h00);
        chk("pslverr", {14'h0000, e}, 15'h0001);
        stop_test();
    end
endmodule
`default_nettype wire
